/* File: host_bus.sv */
// Host controller model driving the register strobes.
// Assumes one-cycle strobes taken at rising edges, data one cycle later.
`timescale 1ns/10ps
`default_nettype none

module host_bus
(
    input  wire logic       clk,
    input  wire logic [7:0] read_data,
    output var  logic [5:0] host_addr,
    output var  logic       reg_write,
    output var  logic       reg_read,
    output var  logic [7:0] write_data
);
// ****************************************
// Register access
// ****************************************
initial
begin
    {host_addr, reg_write, reg_read, write_data} = '0;
end

task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    write_data = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    // Released data shows no stale value
    write_data = ~d;
endtask

task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    d = read_data;
    reg_read = 1'b0;
endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the timer and test-page register bank.
// Assumes the host model issues all register traffic.
`timescale 1ns/10ps
`default_nettype none

module tb;
// ****************************************
// Signals
// ****************************************
logic       clk = 1'b0;
logic       rst_n = 1'b0;
logic       spi_host, uart_host, signal_input_pin, first_auxiliary_pin;
logic       address_pin_three, transmit_done, rf_field_on, initial_rf_on;
logic       timer_start_now, send_command, self_test_command;
logic       oscillator_clock, uart_clock, rf_clock;
logic       aux_line_one_value, aux_line_two_value;
logic [7:0] pb [4] = '{8'h04, 8'hf7, 8'h10, 8'hdf};
logic [6:0] port_in = 7'h55;
logic [1:0] addr_pins_low = 2'b00;
logic       addr_from_pins = 1'b0;
logic       parallel_host = 1'b0;
wire  [7:0] read_data, write_data;
wire  [5:0] host_addr, reg_addr;
wire  [6:0] port_out, port_oe;
wire        reg_write, reg_read, signal_output_pin, secure_clock;
wire        serial_aux_line_one, serial_aux_line_two, timer_expired_flag;
wire        timer_running, prbs9_active, prbs15_active, self_test_run;
int         err_total = 0;
int         comparisons = 0;

always #5 clk = ~clk;

host_bus hb (.clk, .read_data, .host_addr, .reg_write, .reg_read,
    .write_data);

timer_test_regs dut_u (.clk, .rst_n, .host_addr, .addr_pins_low,
    .addr_from_pins, .reg_write, .reg_read, .write_data, .read_data,
    .reg_addr, .parallel_host, .spi_host, .uart_host,
    .signal_input_pin, .first_auxiliary_pin, .address_pin_three,
    .transmit_done, .rf_field_on, .initial_rf_on, .timer_start_now,
    .send_command, .self_test_command, .oscillator_clock, .uart_clock,
    .rf_clock, .probe_bus_a(pb[0]), .probe_bus_b(pb[1]),
    .probe_bus_c(pb[2]), .probe_bus_d(pb[3]), .port_in, .port_out,
    .port_oe, .signal_output_pin, .secure_clock, .serial_aux_line_one,
    .serial_aux_line_two, .aux_line_one_value, .aux_line_two_value,
    .timer_expired_flag, .timer_running, .prbs9_active, .prbs15_active,
    .self_test_run);

// ****************************************
// Helpers
// ****************************************
task automatic check(input string w, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
        err_total++;
        $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
endtask

task automatic rc(input logic [5:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    hb.rd(a, d);
    check(w, 16'(d), 16'(e));
endtask

// Zero exp means no expiry is allowed within the window
task automatic timer_run(input logic [7:0] mode, lo, input logic [15:0] rl,
                         input int how, exp);
    int k;
    hb.wr(6'h2a, mode);
    hb.wr(6'h2b, lo);
    hb.wr(6'h2c, rl[15:8]);
    hb.wr(6'h2d, rl[7:0]);
    @(negedge clk);
    {rf_field_on, transmit_done, timer_start_now} = 3'b001 << how;
    @(negedge clk);
    {rf_field_on, transmit_done, timer_start_now} = 3'b000;
    k = 1;
    while (timer_expired_flag !== 1'b1 && k < (exp ? exp + 4 : 40))
    begin
        @(negedge clk);
        k++;
    end
    check("expiry cycle", 16'(k), 16'(exp ? exp : 40));
endtask

task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask

// ****************************************
// Tests
// ****************************************
logic [5:0] ra [12] = '{6'h2b, 6'h2c, 6'h2d, 6'h30, 6'h31, 6'h32, 6'h33,
                        6'h34, 6'h35, 6'h36, 6'h37, 6'h10};
logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
                        8'h00, 8'h04, 8'h40, 8'h5a, 8'h00};
logic [5:0] wa [8] = '{6'h2b, 6'h2c, 6'h2d, 6'h30, 6'h31, 6'h33, 6'h36, 6'h37};
logic [7:0] wd [8] = '{8'hff, 8'h12, 8'h34, 8'h7c, 8'hff, 8'h7f, 8'hff, 8'h00};
logic [7:0] we [8] = '{8'hff, 8'h12, 8'h34, 8'h00, 8'h3f, 8'h7f, 8'h4f, 8'h5a};

initial
begin
    int k;
    logic [2:0] pat;
    {spi_host, uart_host, signal_input_pin, first_auxiliary_pin} = '0;
    {address_pin_three, transmit_done, rf_field_on, initial_rf_on} = '0;
    {timer_start_now, send_command, self_test_command} = '0;
    {oscillator_clock, uart_clock, rf_clock} = '0;
    {aux_line_one_value, aux_line_two_value} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++)
        rc(ra[i], rv[i], "reset value");
    for (int i = 0; i < 8; i++)
    begin
        hb.wr(wa[i], wd[i]);
        rc(wa[i], we[i], "readback");
    end
    hb.wr(6'h36, 8'h40);
    hb.wr(6'h30, 8'hff);
    rc(6'h30, 8'h83, "page reg");
    rc(6'h06, 8'h40, "paged read");
    check("paged address", 16'(reg_addr), 16'h0036);
    {addr_from_pins, addr_pins_low} = 3'b110;
    rc(6'h04, 8'h40, "pin address");
    addr_from_pins = 1'b0;
    hb.wr(6'h30, 8'h00);
    rc(6'h06, 8'h00, "unpaged read");
    // Expiry seen (reload+1)*(2P+1)+2 sampling points after the start
    timer_run(8'h00, 8'h01, 16'h0005, 0, 20);
    timer_run(8'h01, 8'h00, 16'h0002, 0, 1541);
    timer_run(8'h00, 8'h00, 16'h0100, 0, 259);
    timer_run(8'h00, 8'h00, 16'h0001, 0, 4);
    rc(6'h2f, 8'h00, "count at zero");
    for (int g = 1; g < 4; g++)
    begin
        timer_run(8'(g << 5), 8'h00, 16'h0003, 0, 0);
        rc(6'h2f, 8'h03, "frozen count");
        hb.wr(6'h2d, 8'h09);
        rc(6'h2f, 8'h03, "count after reload write");
        {address_pin_three, first_auxiliary_pin, signal_input_pin}
            = 3'b001 << (g - 1);
        k = 0;
        while (timer_expired_flag !== 1'b1 && k < 12)
        begin
            @(negedge clk);
            k++;
        end
        check("gated expiry", 16'(k < 12), 16'h0001);
        {address_pin_three, first_auxiliary_pin, signal_input_pin} = '0;
    end
    @(negedge clk) timer_start_now = 1'b1;
    @(negedge clk) timer_start_now = 1'b0;
    rc(6'h2f, 8'h09, "new reload");
    timer_run(8'h10, 8'h00, 16'h0002, 0, 0);
    check("still running", 16'(timer_running), 16'h0001);
    initial_rf_on = 1'b1;
    timer_run(8'h80, 8'h00, 16'h0001, 1, 4);
    timer_run(8'h80, 8'h00, 16'h0001, 2, 4);
    timer_run(8'h00, 8'h00, 16'h0001, 1, 0);
    for (int s = 0; s < 4; s++)
    begin
        hb.wr(6'h32, 8'(s));
        hb.wr(6'h31, 8'(s + 2));
        rc(6'h35, pb[s], "test bus");
        check("probe bit", 16'(signal_output_pin),
              16'(pb[s][s+2]));
    end
    for (int p = 0; p < 2; p++)
        for (int c = 0; c < 4; c++)
        begin
            pat = p ? 3'b010 : 3'b101;
            {rf_clock, uart_clock, oscillator_clock} = pat;
            hb.wr(6'h31, 8'(c << 4));
            repeat (3) @(negedge clk);
            check("secure clock", 16'(secure_clock),
                  16'(c ? pat[c-1] : 1'b0));
        end
    // Sequence is configured before send, as the host must
    hb.wr(6'h32, 8'h40);
    check("prbs idle", 16'(prbs9_active), 16'h0000);
    @(negedge clk) send_command = 1'b1;
    @(negedge clk) send_command = 1'b0;
    @(negedge clk);
    check("prbs9", 16'(prbs9_active), 16'h0001);
    hb.wr(6'h32, 8'h20);
    @(negedge clk) send_command = 1'b1;
    @(negedge clk) send_command = 1'b0;
    @(negedge clk);
    check("prbs15", 16'(prbs15_active), 16'h0001);
    hb.wr(6'h32, 8'h00);
    hb.wr(6'h36, 8'h49);
    @(negedge clk) self_test_command = 1'b1;
    @(negedge clk) self_test_command = 1'b0;
    @(negedge clk);
    check("self test", 16'(self_test_run), 16'h0001);
    hb.wr(6'h36, 8'h40);
    // Run flag follows the code one edge after the write lands
    @(negedge clk);
    check("self test off", 16'(self_test_run), 16'h0000);
    uart_host = 1'b1;
    {aux_line_two_value, aux_line_one_value} = 2'b11;
    hb.wr(6'h33, 8'h03);
    @(negedge clk);
    check("aux off", 16'(serial_aux_line_one), 16'h0000);
    hb.wr(6'h33, 8'h83);
    hb.wr(6'h34, 8'h82);
    @(negedge clk);
    check("aux on", 16'(serial_aux_line_two), 16'h0001);
    check("port drive", {2'b00, port_oe, port_out}, 16'h0182);
    rc(6'h34, 8'hd5, "live pins");
    hb.wr(6'h34, 8'h02);
    rc(6'h34, 8'h02, "pin register");
    hb.wr(6'h33, 8'h7f);
    hb.wr(6'h32, 8'h81);
    @(negedge clk);
    check("reordered bus", {2'b00, port_oe, port_out}, 16'h3fbf);
    hb.wr(6'h31, 8'h08);
    @(negedge clk);
    check("clock on d1", 16'(port_out), 16'h003d);
    parallel_host = 1'b1;
    @(negedge clk);
    check("d1 released", 16'(port_out), 16'h003f);
    wrap_up;
end

initial
begin
    #300000;
    err_total++;
    wrap_up;
end
endmodule
`default_nettype wire

/* File: timer_countdown.v */
// Prescaled 16-bit countdown timer with gating and auto reload.
// Assumes gate and start inputs synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module timer_countdown
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire [11:0] prescale_divisor,
    input  wire [15:0] reload_value,
    input  wire        reload_on_zero,
    input  wire        gate_open,
    input  wire        start,
    output reg  [15:0] count,
    output reg         running,
    output reg         expired_pulse
);

// ********************************************************
// Prescaler and counter
// ********************************************************
// Tick every 2*divisor+1 clocks, so frequency is clk/(2p+1)
reg  [12:0] pre_count;
wire [12:0] pre_limit = {prescale_divisor, 1'b0};
wire        tick      = (pre_count == pre_limit);

always @(posedge clk)
begin
    if (!rst_n)
    begin
        pre_count     <= 13'h0000;
        count         <= 16'h0000;
        running       <= 1'b0;
        expired_pulse <= 1'b0;
    end
    else
    begin
        expired_pulse <= 1'b0;
        if (start)
        begin
            count     <= reload_value;
            pre_count <= 13'h0000;
            running   <= 1'b1;
        end
        else if (running && gate_open)
        begin
            pre_count <= tick ? 13'h0000 : pre_count + 13'h0001;
            if (tick)
            begin
                if (count == 16'h0000)
                begin
                    expired_pulse <= 1'b1;
                    if (reload_on_zero)
                        count <= reload_value;
                    else
                        running <= 1'b0;
                end
                else
                    count <= count - 16'h0001;
            end
        end
    end
end

endmodule

`default_nettype wire

/* File: timer_test_consts.vh */
// Constants for the timer and test-page register bank.
// Assumes byte-wide registers on a 6-bit register address.
`ifndef TIMER_TEST_CONSTS_VH
`define TIMER_TEST_CONSTS_VH

// ********************************************************
// Register offsets
// ********************************************************
`define ADDR_TIMER_MODE        6'h2a
`define ADDR_PRESCALE_LOW      6'h2b
`define ADDR_RELOAD_HIGH       6'h2c
`define ADDR_RELOAD_LOW        6'h2d
`define ADDR_COUNT_HIGH        6'h2e
`define ADDR_COUNT_LOW         6'h2f
`define ADDR_PAGE_SELECT       6'h30
`define ADDR_TEST_SEL_ONE      6'h31
`define ADDR_TEST_SEL_TWO      6'h32
`define ADDR_PIN_ENABLE        6'h33
`define ADDR_PIN_VALUE         6'h34
`define ADDR_TEST_BUS          6'h35
`define ADDR_SELF_TEST         6'h36
`define ADDR_VERSION           6'h37

// ********************************************************
// Reset values and masks
// ********************************************************
`define RST_TIMER_MODE         8'h00
`define RST_PRESCALE_LOW       8'h00
`define RST_RELOAD             8'h00
`define RST_PAGE_SELECT        8'h00
`define RST_TEST_SEL           8'h00
`define RST_PIN_ENABLE         8'h80
`define RST_PIN_VALUE          8'h00
`define RST_SELF_TEST          8'h40
`define MASK_PAGE_SELECT       8'h83
`define MASK_TEST_SEL_ONE      8'h3f
`define MASK_SELF_TEST         8'h4f

// ********************************************************
// Field positions and codes
// ********************************************************
`define BIT_PROTOCOL_START     7
`define BIT_RELOAD_ON_ZERO     4
`define BIT_PAGE_ENABLE        7
`define BIT_CLOCK_TO_PIN       3
`define BIT_BUS_REORDER        7
`define BIT_PRBS9              6
`define BIT_PRBS15             5
`define BIT_AUX_LINES          7
`define BIT_GPIO_ENABLE        7
`define GATE_NONE              2'h0
`define GATE_SIGNAL_IN         2'h1
`define GATE_AUX_ONE           2'h2
`define GATE_ADDR_THREE        2'h3
`define SELF_TEST_ON           4'h9
`define VERSION_CODE           8'h5a

`endif

/* File: timer_test_regs.v */
// Timer and test-page register bank with pin control.
// Assumes a host interface front end giving one-cycle read/write strobes
// with a 6-bit latched address; all inputs synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "timer_test_consts.vh"

module timer_test_regs
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire [5:0]  host_addr,
    input  wire [1:0]  addr_pins_low,
    input  wire        addr_from_pins,
    input  wire        reg_write,
    input  wire        reg_read,
    input  wire [7:0]  write_data,
    output reg  [7:0]  read_data,
    output reg  [5:0]  reg_addr,
    input  wire        parallel_host,
    input  wire        spi_host,
    input  wire        uart_host,
    input  wire        signal_input_pin,
    input  wire        first_auxiliary_pin,
    input  wire        address_pin_three,
    input  wire        transmit_done,
    input  wire        rf_field_on,
    input  wire        initial_rf_on,
    input  wire        timer_start_now,
    input  wire        send_command,
    input  wire        self_test_command,
    input  wire        oscillator_clock,
    input  wire        uart_clock,
    input  wire        rf_clock,
    input  wire [7:0]  probe_bus_a,
    input  wire [7:0]  probe_bus_b,
    input  wire [7:0]  probe_bus_c,
    input  wire [7:0]  probe_bus_d,
    input  wire [6:0]  port_in,
    output reg  [6:0]  port_out,
    output reg  [6:0]  port_oe,
    output reg         signal_output_pin,
    output reg         secure_clock,
    output reg         serial_aux_line_one,
    output reg         serial_aux_line_two,
    input  wire        aux_line_one_value,
    input  wire        aux_line_two_value,
    output reg         timer_expired_flag,
    output reg         timer_running,
    output reg         prbs9_active,
    output reg         prbs15_active,
    output reg         self_test_run
);

// ********************************************************
// Storage
// ********************************************************
reg  [7:0] timer_mode_control;
reg  [7:0] timer_prescale_low;
reg  [7:0] timer_reload_high;
reg  [7:0] timer_reload_low;
reg  [7:0] register_page_select;
reg  [7:0] test_signal_select_one;
reg  [7:0] test_signal_select_two;
reg  [7:0] port_pin_enable;
reg  [7:0] port_pin_value;
reg  [7:0] self_test_control;

wire [1:0]  timer_gate_select     = timer_mode_control[6:5];
wire        timer_protocol_start  = timer_mode_control[`BIT_PROTOCOL_START];
wire        timer_reload_on_zero  = timer_mode_control[`BIT_RELOAD_ON_ZERO];
wire [3:0]  prescale_upper_nibble = timer_mode_control[3:0];
wire [7:0]  prescale_lower_byte   = timer_prescale_low;
wire [11:0] prescale_divisor      = {prescale_upper_nibble,
                                     prescale_lower_byte};
wire [15:0] reload_value = {timer_reload_high, timer_reload_low};
wire        page_field_enable   = register_page_select[`BIT_PAGE_ENABLE];
wire [1:0]  register_page_field = register_page_select[1:0];
wire [1:0]  secure_clock_source = test_signal_select_one[5:4];
wire        secure_clock_to_pin =
                test_signal_select_one[`BIT_CLOCK_TO_PIN];
wire [2:0]  probe_bit_select    = test_signal_select_one[2:0];
wire        probe_bus_reorder   = test_signal_select_two[`BIT_BUS_REORDER];
wire [4:0]  probe_bus_select    = test_signal_select_two[4:0];
wire        serial_aux_lines_enable = port_pin_enable[`BIT_AUX_LINES];
wire [6:0]  port_output_enables = port_pin_enable[6:0];
wire        port_gpio_enable    = port_pin_value[`BIT_GPIO_ENABLE];
wire [6:0]  port_pin_levels     = port_pin_value[6:0];

// ********************************************************
// Address formation
// ********************************************************
wire [5:0] latch_addr = addr_from_pins ?
                        {host_addr[5:2], addr_pins_low} : host_addr;
wire [5:0] next_reg_addr = page_field_enable ?
           {register_page_field, latch_addr[3:0]} :
           host_addr;

// ********************************************************
// Timer
// ********************************************************
reg gate_open;
always @*
begin
    case (timer_gate_select)
        `GATE_SIGNAL_IN:  gate_open = signal_input_pin;
        `GATE_AUX_ONE:    gate_open = first_auxiliary_pin;
        `GATE_ADDR_THREE: gate_open = address_pin_three;
        default:          gate_open = 1'b1;
    endcase
end

// Automatic start only from protocol events; a manual start always works
wire timer_start = timer_start_now ||
                   (timer_protocol_start &&
                    (transmit_done ||
                     (initial_rf_on && rf_field_on)));

wire [15:0] count;
wire        running;
wire        expired_pulse;

timer_countdown u_timer
(
    .clk              (clk),
    .rst_n            (rst_n),
    .prescale_divisor (prescale_divisor),
    .reload_value     (reload_value),   // latched on start and on auto reload at zero
    .reload_on_zero   (timer_reload_on_zero),
    .gate_open        (gate_open),
    .start            (timer_start),
    .count            (count),
    .running          (running),
    .expired_pulse    (expired_pulse)
);

// ********************************************************
// Test bus selection
// ********************************************************
reg [7:0] probe_bus;
always @*
begin
    case (probe_bus_select[1:0])
        2'h0:    probe_bus = probe_bus_a;
        2'h1:    probe_bus = probe_bus_b;
        2'h2:    probe_bus = probe_bus_c;
        default: probe_bus = probe_bus_d;
    endcase
end

// Reorder puts bus bits 6..0 on D4,D3,D2,D6,D5,D0,D1
wire [6:0] probe_on_port = probe_bus_reorder ?
           {probe_bus[3], probe_bus[2], probe_bus[6], probe_bus[5],
            probe_bus[4], probe_bus[0], probe_bus[1]} :
           probe_bus[6:0];

reg next_secure_clock;
always @*
begin
    case (secure_clock_source)
        2'h1:    next_secure_clock = oscillator_clock;
        2'h2:    next_secure_clock = uart_clock;
        2'h3:    next_secure_clock = rf_clock;
        default: next_secure_clock = 1'b0;
    endcase
end

// ********************************************************
// Parallel port drive
// ********************************************************
// SPI host limits usable pins to D0-D4; UART with aux lines keeps D5/D6 busy
wire       serial_host = spi_host || uart_host;
wire       narrow_port = spi_host ||
                         (uart_host && serial_aux_lines_enable);
wire [6:0] usable_pins = narrow_port ? 7'h1f : 7'h7f;
wire       clock_on_d1 = secure_clock_to_pin && !parallel_host;
wire       gpio_mode   = serial_host && port_gpio_enable;
reg  [6:0] next_port_out;
reg  [6:0] next_port_oe;
always @*
begin
    next_port_out = 7'h00;
    next_port_oe  = 7'h00;
    if (gpio_mode)
    begin
        next_port_out = port_pin_levels;
        next_port_oe  = port_output_enables & usable_pins;
    end
    else if (serial_host)
    begin
        next_port_out = probe_on_port;
        next_port_oe  = port_output_enables & usable_pins;
    end
    if (clock_on_d1)
    begin
        next_port_out[1] = next_secure_clock;
        next_port_oe[1]  = 1'b1;
    end
end

// ********************************************************
// Register read mux
// ********************************************************
reg [7:0] next_read_data;
always @*
begin
    case (next_reg_addr)
        `ADDR_TIMER_MODE:   next_read_data = timer_mode_control;
        `ADDR_PRESCALE_LOW: next_read_data = timer_prescale_low;
        `ADDR_RELOAD_HIGH:  next_read_data = timer_reload_high;
        `ADDR_RELOAD_LOW:   next_read_data = timer_reload_low;
        `ADDR_COUNT_HIGH:   next_read_data = count[15:8];
        `ADDR_COUNT_LOW:    next_read_data = count[7:0];
        `ADDR_PAGE_SELECT:  next_read_data = register_page_select;
        `ADDR_TEST_SEL_ONE: next_read_data = test_signal_select_one;
        `ADDR_TEST_SEL_TWO: next_read_data = test_signal_select_two;
        `ADDR_PIN_ENABLE:   next_read_data = port_pin_enable;
        `ADDR_PIN_VALUE:    next_read_data = port_gpio_enable ?
                                {1'b1, port_in} :
                                port_pin_value;
        `ADDR_TEST_BUS:     next_read_data = probe_bus;
        `ADDR_SELF_TEST:    next_read_data = self_test_control;
        `ADDR_VERSION:      next_read_data = `VERSION_CODE;
        default:            next_read_data = 8'h00;
    endcase
end

// ********************************************************
// Register writes and outputs
// ********************************************************
always @(posedge clk)
begin
    if (!rst_n)
    begin
        timer_mode_control     <= `RST_TIMER_MODE;
        timer_prescale_low     <= `RST_PRESCALE_LOW;
        timer_reload_high      <= `RST_RELOAD;
        timer_reload_low       <= `RST_RELOAD;
        register_page_select   <= `RST_PAGE_SELECT;
        test_signal_select_one <= `RST_TEST_SEL;
        test_signal_select_two <= `RST_TEST_SEL;
        port_pin_enable        <= `RST_PIN_ENABLE;
        port_pin_value         <= `RST_PIN_VALUE;
        self_test_control      <= `RST_SELF_TEST;
        read_data              <= 8'h00;
        reg_addr               <= 6'h00;
        port_out               <= 7'h00;
        port_oe                <= 7'h00;
        signal_output_pin      <= 1'b0;
        secure_clock           <= 1'b0;
        serial_aux_line_one    <= 1'b0;
        serial_aux_line_two    <= 1'b0;
        timer_expired_flag     <= 1'b0;
        timer_running          <= 1'b0;
        prbs9_active           <= 1'b0;
        prbs15_active          <= 1'b0;
        self_test_run          <= 1'b0;
    end
    else
    begin
        if (reg_write)
        begin
            case (next_reg_addr)
                `ADDR_TIMER_MODE:   timer_mode_control <= write_data;
                `ADDR_PRESCALE_LOW: timer_prescale_low <= write_data;
                `ADDR_RELOAD_HIGH:  timer_reload_high  <= write_data;
                `ADDR_RELOAD_LOW:   timer_reload_low   <= write_data;
                `ADDR_PAGE_SELECT:  register_page_select <=
                    write_data & `MASK_PAGE_SELECT;
                `ADDR_TEST_SEL_ONE: test_signal_select_one <=
                    write_data & `MASK_TEST_SEL_ONE;
                `ADDR_TEST_SEL_TWO: test_signal_select_two <= write_data;
                `ADDR_PIN_ENABLE:   port_pin_enable    <= write_data;
                `ADDR_PIN_VALUE:    port_pin_value     <= write_data;
                `ADDR_SELF_TEST:    self_test_control <=
                    write_data & `MASK_SELF_TEST;
                default:            ;
            endcase
        end
        read_data <= reg_read ? next_read_data : 8'h00;
        reg_addr  <= next_reg_addr;
        port_out  <= next_port_out;
        port_oe   <= next_port_oe;
        signal_output_pin <= probe_bus[probe_bit_select];
        secure_clock <= next_secure_clock;
        // Aux lines held low while disabled
        serial_aux_line_one <= serial_aux_lines_enable &&
                               aux_line_one_value;
        serial_aux_line_two <= serial_aux_lines_enable &&
                               aux_line_two_value;
        // One-cycle expiry pulse without auto reload is the flag event for the interrupt logic
        timer_expired_flag <= expired_pulse &&
                              !timer_reload_on_zero;
        timer_running <= running;
        // Sequence only leaves after send, so registers must be set up first
        if (send_command)
        begin
            prbs9_active  <= test_signal_select_two[`BIT_PRBS9];
            prbs15_active <= test_signal_select_two[`BIT_PRBS15];
        end
        else if (!test_signal_select_two[`BIT_PRBS9] &&
                 !test_signal_select_two[`BIT_PRBS15])
        begin
            prbs9_active  <= 1'b0;
            prbs15_active <= 1'b0;
        end
        if (self_test_command &&
            self_test_control[3:0] == `SELF_TEST_ON)
            self_test_run <= 1'b1;
        else if (self_test_control[3:0] != `SELF_TEST_ON)
            self_test_run <= 1'b0;
    end
end

endmodule

`default_nettype wire

/* File: timer_test_regs_monitor.sv */
// Concurrent checks on the timer and test-page register bank pins.
// Assumes it is bound to every instance of timer_test_regs.
`timescale 1ns/10ps
`default_nettype none

module timer_test_regs_monitor
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_read,
    input wire logic [7:0] read_data,
    input wire logic       send_command,
    input wire logic       self_test_command,
    input wire logic       oscillator_clock,
    input wire logic       uart_clock,
    input wire logic       rf_clock,
    input wire logic       aux_line_one_value,
    input wire logic       aux_line_two_value,
    input wire logic       secure_clock,
    input wire logic       serial_aux_line_one,
    input wire logic       serial_aux_line_two,
    input wire logic       timer_expired_flag,
    input wire logic       prbs9_active,
    input wire logic       prbs15_active,
    input wire logic       self_test_run
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);

// ****************************************
// Checks
// ****************************************
read_quiet_a:
    assert property (read_data != 8'h00 |-> $past(reg_read))
    else $error("read data outside a read slot");
aux_one_gate_a:
    assert property (serial_aux_line_one |-> $past(aux_line_one_value))
    else $error("aux line one high without its value");
aux_two_gate_a:
    assert property (serial_aux_line_two |-> $past(aux_line_two_value))
    else $error("aux line two high without its value");
secure_clock_src_a:
    assert property (secure_clock |->
        $past(oscillator_clock) || $past(uart_clock) || $past(rf_clock))
    else $error("secure clock high with every source low");
expiry_pulse_a:
    assert property (timer_expired_flag |=> !timer_expired_flag)
    else $error("expiry flag longer than one cycle");
prbs9_start_a:
    assert property ($rose(prbs9_active) |-> $past(send_command))
    else $error("short sequence started without send");
prbs15_start_a:
    assert property ($rose(prbs15_active) |-> $past(send_command))
    else $error("long sequence started without send");
self_test_go_a:
    assert property ($rose(self_test_run) |-> $past(self_test_command))
    else $error("self test started without its command");
endmodule

bind timer_test_regs timer_test_regs_monitor mon_u (.clk, .rst_n, .reg_read,
    .read_data, .send_command, .self_test_command, .oscillator_clock,
    .uart_clock, .rf_clock, .aux_line_one_value, .aux_line_two_value,
    .secure_clock, .serial_aux_line_one, .serial_aux_line_two,
    .timer_expired_flag, .prbs9_active, .prbs15_active, .self_test_run);
`default_nettype wire
